// ==== rtl/dsp_agu_map.vh ====
// constants for the dsp data address generator
`ifndef DSP_AGU_MAP_VH
`define DSP_AGU_MAP_VH
// addressing modes
`define AM_NOP 2'h0
`define AM_INC 2'h1
`define AM_IDX 2'h2
`define AM_DEC 2'h3
// transfer kinds
`define OP_NONE 2'h0
`define OP_XY 2'h1
`define OP_SINGLE 2'h2
// step sizes
`define STEP_WORD 32'h0000_0002
`define STEP_LONG 32'h0000_0004
// modulo bounds register field positions
`define MOD_END_HI 31
`define MOD_END_LO 16
`define MOD_START_HI 15
`define MOD_START_LO 0
// register numbers
`define REG_X_INDEX 4'h8
`define REG_Y_INDEX 4'h9
// reset values
`define MOD_RESET 32'h0000_0000
`endif

// ==== rtl/dsp_data_address_generator.v ====
// dsp data address generator: x/y and single transfer addressing
`timescale 1ns/1ps
module dsp_data_address_generator (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // request from the pipeline
  input wire req_valid,
  input wire [1:0] req_kind,
  input wire x_sel,
  input wire y_sel,
  input wire [1:0] x_mode,
  input wire [1:0] y_mode,
  input wire [1:0] single_sel,
  input wire [1:0] single_mode,
  input wire single_long,
  // status register modulo bits
  input wire x_modulo_enable,
  input wire y_modulo_enable,
  // control register load of the bounds register
  input wire control_register_load,
  input wire [31:0] load_data,
  // general register values r2..r9
  input wire [31:0] gr2,
  input wire [31:0] gr3,
  input wire [31:0] gr4,
  input wire [31:0] gr5,
  input wire [31:0] gr6,
  input wire [31:0] gr7,
  input wire [31:0] gr8,
  input wire [31:0] gr9,
  // x and y data bus addresses
  output reg x_req_r,
  output reg [15:1] x_addr_r,
  output reg y_req_r,
  output reg [15:1] y_addr_r,
  // main data bus address
  output reg main_req_r,
  output reg [31:0] main_addr_r,
  output reg main_long_r,
  // pointer write-back to the register file
  output reg wb_a_en_r,
  output reg [3:0] wb_a_num_r,
  output reg [31:0] wb_a_data_r,
  output reg wb_b_en_r,
  output reg [3:0] wb_b_num_r,
  output reg [31:0] wb_b_data_r,
  // bounds register readback
  output reg [31:0] modulo_bounds_register_r
);
`include "dsp_agu_map.vh"

////////////////////////////////////////////////////////////////////////
// operand selection

  reg [31:0] x_pointer;
  reg [31:0] y_pointer;
  reg [31:0] single_pointer;
  wire [31:0] x_index;
  wire [31:0] y_index;
  wire [31:0] single_index;
  wire [15:0] modulo_start;
  wire [15:0] modulo_end;
  wire x_mod_on;
  wire y_mod_on;
  wire [31:0] x_nxt;
  wire [31:0] y_nxt;
  wire [31:0] s_addr;
  wire [31:0] s_nxt;
  wire [3:0] x_num;
  wire [3:0] y_num;
  wire [3:0] s_num;
  wire do_xy;
  wire do_single;

  // fixed index registers; no immediate operand path exists
  assign x_index = gr8;
  assign y_index = gr9;
  assign single_index = gr8;

  // pointer muxes
  always @* begin
    x_pointer = x_sel ? gr5 : gr4;
    y_pointer = y_sel ? gr7 : gr6;
    case (single_sel)
      2'h0: single_pointer = gr2;
      2'h1: single_pointer = gr3;
      2'h2: single_pointer = gr4;
      default: single_pointer = gr5;
    endcase
  end
  assign x_num = x_sel ? 4'h5 : 4'h4;
  assign y_num = y_sel ? 4'h7 : 4'h6;
  assign s_num = {2'b00, single_sel} + 4'h2;

  // 16-bit fields bound the region to 64 kbytes
  assign modulo_end = modulo_bounds_register_r[`MOD_END_HI:`MOD_END_LO];
  assign modulo_start =
    modulo_bounds_register_r[`MOD_START_HI:`MOD_START_LO];

  // y wins when both enables are set; single moves never wrap
  assign x_mod_on = x_modulo_enable & ~y_modulo_enable;
  assign y_mod_on = y_modulo_enable;

  assign do_xy = req_valid && req_kind == `OP_XY;
  assign do_single = req_valid && req_kind == `OP_SINGLE;

////////////////////////////////////////////////////////////////////////
// next-value units

  xy_pointer_update u_x_update (
    .ptr(x_pointer),
    .index(x_index),
    .mode(x_mode),
    .mod_on(x_mod_on),
    .mod_start(modulo_start),
    .mod_end(modulo_end),
    .ptr_nxt(x_nxt)
  );

  xy_pointer_update u_y_update (
    .ptr(y_pointer),
    .index(y_index),
    .mode(y_mode),
    .mod_on(y_mod_on),
    .mod_start(modulo_start),
    .mod_end(modulo_end),
    .ptr_nxt(y_nxt)
  );

  single_pointer_update u_s_update (
    .ptr(single_pointer),
    .index(single_index),
    .mode(single_mode),
    .is_long(single_long),
    .addr(s_addr),
    .ptr_nxt(s_nxt)
  );

////////////////////////////////////////////////////////////////////////
// bounds register

  // both fields loaded together by one load
  always @(posedge core_clk) begin
    if (rst)
      modulo_bounds_register_r <= `MOD_RESET;
    else if (control_register_load)
      modulo_bounds_register_r <= load_data;
  end

////////////////////////////////////////////////////////////////////////
// addresses and write-back, one cycle after the request

  always @(posedge core_clk) begin
    if (rst) begin
      x_req_r <= 1'b0;
      x_addr_r <= 15'h0000;
      y_req_r <= 1'b0;
      y_addr_r <= 15'h0000;
      main_req_r <= 1'b0;
      main_addr_r <= 32'h0000_0000;
      main_long_r <= 1'b0;
      wb_a_en_r <= 1'b0;
      wb_a_num_r <= 4'h0;
      wb_a_data_r <= 32'h0000_0000;
      wb_b_en_r <= 1'b0;
      wb_b_num_r <= 4'h0;
      wb_b_data_r <= 32'h0000_0000;
    end else begin
      // x/y word accesses on their own buses, no contention
      x_req_r <= do_xy;
      y_req_r <= do_xy;
      main_req_r <= do_single;
      main_long_r <= do_single & single_long;
      wb_a_en_r <= 1'b0;
      wb_b_en_r <= 1'b0;
      if (do_xy) begin
        // old pointer, bits 1-15; upper half and bit 0 dropped
        x_addr_r <= x_pointer[15:1];
        y_addr_r <= y_pointer[15:1];
        // nop mode writes nothing back
        wb_a_en_r <= x_mode != `AM_NOP;
        wb_a_num_r <= x_num;
        wb_a_data_r <= x_nxt;
        wb_b_en_r <= y_mode != `AM_NOP;
        wb_b_num_r <= y_num;
        wb_b_data_r <= y_nxt;
      end else if (do_single) begin
        main_addr_r <= s_addr;
        wb_a_en_r <= single_mode != `AM_NOP;
        wb_a_num_r <= s_num;
        wb_a_data_r <= s_nxt;
      end
    end
  end
endmodule

// ==== rtl/single_pointer_update.v ====
// address and next value for a single-transfer pointer
`timescale 1ns/1ps
module single_pointer_update (
  // pointer and step
  input wire [31:0] ptr,
  input wire [31:0] index,
  input wire [1:0] mode,
  input wire is_long,
  // results
  output reg [31:0] addr,
  output reg [31:0] ptr_nxt
);
`include "dsp_agu_map.vh"
  reg [31:0] size;
  // post-update uses old value; decrement updates first
  always @* begin
    size = is_long ? `STEP_LONG : `STEP_WORD;
    addr = ptr;
    ptr_nxt = ptr;
    case (mode)
      `AM_INC: ptr_nxt = ptr + size;
      `AM_IDX: ptr_nxt = ptr + index;
      `AM_DEC: begin
        ptr_nxt = ptr - size;
        addr = ptr - size;
      end
      default: ptr_nxt = ptr;
    endcase
  end
endmodule

// ==== rtl/xy_pointer_update.v ====
// next-value logic for one dual x/y pointer, with modulo wrap
`timescale 1ns/1ps
module xy_pointer_update (
  // pointer and step
  input wire [31:0] ptr,
  input wire [31:0] index,
  input wire [1:0] mode,
  // modulo control
  input wire mod_on,
  input wire [15:0] mod_start,
  input wire [15:0] mod_end,
  // result
  output reg [31:0] ptr_nxt
);
`include "dsp_agu_map.vh"
  reg [31:0] step;
  reg [15:0] low_sum;
  // only the lower halfword is written; upper halfword kept
  always @* begin
    step = 32'h0000_0000;
    if (mode == `AM_INC)
      step = `STEP_WORD;
    else if (mode == `AM_IDX)
      step = index;
    // with modulo off plain add is used, no compare
    low_sum = ptr[15:0] + step[15:0];
    ptr_nxt = {ptr[31:16], low_sum};
    // exact match only; stepping past the end does not wrap
    if (mod_on && mode != `AM_NOP && ptr[15:0] == mod_end)
      ptr_nxt = {ptr[31:16], mod_start[15:1], ptr[0]};
  end
endmodule

// ==== test/dsp_agu_checker.sv ====
// port assertions for the dsp data address generator
`timescale 1ns/1ps
module dsp_agu_checker (
  // clock, reset and request
  input wire core_clk, rst, req_valid, x_sel, y_sel, single_long,
  input wire [1:0] req_kind, x_mode, y_mode, single_sel, single_mode,
  input wire x_modulo_enable, control_register_load,
  input wire [31:0] load_data, gr3, gr4, gr5, gr7, gr8,
  // outputs
  input wire x_req_r, y_req_r, main_req_r,
  input wire [15:1] x_addr_r,
  input wire [3:0] wb_a_num_r,
  input wire [31:0] main_addr_r, wb_a_data_r, wb_b_data_r,
  input wire [31:0] modulo_bounds_register_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // decoded request kinds
  wire xy = req_valid && req_kind == 2'h1;
  wire sg = req_valid && req_kind == 2'h2;
  AST_XY_STROBES: assert property (
    xy |=> x_req_r && y_req_r && !main_req_r) else $error("xy strobes");
  AST_X_ADDR: assert property (
    xy && x_sel |=> x_addr_r == $past(gr5[15:1])) else $error("x addr");
  AST_Y_UPPER: assert property (
    xy && y_sel && y_mode != 2'h0 |=>
    wb_b_data_r[31:16] == $past(gr7[31:16])) else $error("y upper");
  AST_X_INDEX: assert property (
    xy && !x_sel && x_mode == 2'h2 && !x_modulo_enable |=>
    wb_a_data_r[15:0] == $past(gr4[15:0]) + $past(gr8[15:0]))
    else $error("x index");
  AST_X_INC: assert property (
    xy && x_sel && x_mode == 2'h1 && !x_modulo_enable |=>
    wb_a_data_r[15:0] == $past(gr5[15:0]) + 16'h0002) else $error("x inc");
  // pre-decrement: reduced value both addresses and writes back
  AST_S_DEC: assert property (
    sg && single_sel == 2'h3 && single_mode == 2'h3 |=>
    main_addr_r == $past(gr5) - ($past(single_long) ? 3'h4 : 3'h2) &&
    wb_a_data_r == main_addr_r) else $error("single dec");
  AST_S_POST: assert property (
    sg && single_sel == 2'h1 && single_mode == 2'h1 |=>
    main_addr_r == $past(gr3) && wb_a_num_r == 4'h3 &&
    wb_a_data_r == $past(gr3) + ($past(single_long) ? 3'h4 : 3'h2))
    else $error("single post");
  AST_LOAD: assert property (
    control_register_load |=> modulo_bounds_register_r == $past(load_data))
    else $error("bounds load");
endmodule
bind dsp_data_address_generator dsp_agu_checker u_dsp_agu_checker (.*);

// ==== test/dsp_data_address_generator_tb.sv ====
// directed bench for the dsp data address generator
`timescale 1ns/1ps
module dsp_data_address_generator_tb;
  reg core_clk = 0, rst = 1, req_valid = 0, x_sel = 0, y_sel = 0;
  reg single_long = 0, x_modulo_enable = 0, y_modulo_enable = 0;
  reg control_register_load = 0;
  reg [1:0] req_kind = 0, x_mode = 0, y_mode = 0;
  reg [1:0] single_sel = 0, single_mode = 0;
  reg [31:0] load_data = 0, gr2 = 0, gr3 = 0, gr4 = 0, gr5 = 0;
  reg [31:0] gr6 = 0, gr7 = 0, gr8 = 0, gr9 = 0, e, b, s;
  wire x_req_r, y_req_r, main_req_r, main_long_r, wb_a_en_r, wb_b_en_r;
  wire [15:1] x_addr_r, y_addr_r;
  wire [3:0] wb_a_num_r, wb_b_num_r;
  wire [31:0] main_addr_r, wb_a_data_r, wb_b_data_r;
  wire [31:0] modulo_bounds_register_r;
  wire [7:0] hits;
  integer err_total = 0, checked = 0, cyc = 0, i;
  dsp_data_address_generator u_dsp_data_address_generator (.*);
  xy_memory_model u_xy_memory_model (.*);
  // clock and hang guard
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 500) begin
      err_total = err_total + 1;
      wrap_up;
    end
  end
  task chk(input [255:0] n, input [31:0] x, input [31:0] g);
    begin
      checked = checked + 1;
      if (x !== g) begin
        err_total = err_total + 1;
        $display("CHECK FAILED %0s exp %h got %h", n, x, g);
      end
    end
  endtask
  // one-cycle request; returns where the answer stands
  task go(input [1:0] k);
    begin
      @(negedge core_clk);
      req_kind = k;
      req_valid = 1;
      @(negedge core_clk);
      req_valid = 0;
    end
  endtask
  task xy(input [1:0] xm, input [1:0] ym);
    begin
      x_mode = xm;
      y_mode = ym;
      go(2'h1);
    end
  endtask
  task wrap_up;
    begin
      $display("errors %0d checks %0d", err_total, checked);
      if (err_total == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    repeat (5) @(negedge core_clk);
    rst = 0;
    chk("bounds rst", 32'h0000_0000, modulo_bounds_register_r);
    load_data = 32'h700c_7008;
    control_register_load = 1;
    @(negedge core_clk);
    control_register_load = 0;
    chk("bounds", 32'h700c_7008, modulo_bounds_register_r);
    // x ring walk, write-back fed to the pointer; even values only
    gr4 = 32'ha500_7008;
    x_modulo_enable = 1;
    for (i = 0; i < 3; i = i + 1) begin
      e = gr4;
      xy(2'h1, 2'h0);
      chk("x addr", e[15:1], x_addr_r);
      e[15:0] = (i == 2) ? 16'h7008 : e[15:0] + 16'h0002;
      chk("x ring", e, wb_a_data_r);
      chk("x wb en", 32'h0000_0001, wb_a_en_r);
      chk("y nop", 32'h0000_0000, wb_b_en_r);
      gr4 = wb_a_data_r;
    end
    // both enables: only y wraps
    y_modulo_enable = 1;
    gr4 = 32'h0000_700c;
    gr7 = 32'h1111_700c;
    y_sel = 1;
    xy(2'h1, 2'h1);
    chk("x plain", 32'h0000_700e, wb_a_data_r);
    chk("y wrap", 32'h1111_7008, wb_b_data_r);
    chk("y num", 32'h0000_0007, wb_b_num_r);
    // step down by minus two; y index jumps past the end
    x_modulo_enable = 0;
    gr4 = 32'h2222_7000;
    gr7 = 32'h1111_700a;
    gr8 = 32'hffff_fffe;
    gr9 = 32'h0000_0004;
    xy(2'h2, 2'h2);
    chk("x down", 32'h2222_6ffe, wb_a_data_r);
    chk("y past end", 32'h1111_700e, wb_b_data_r);
    // y low half rolls over, upper half kept
    y_modulo_enable = 0;
    x_sel = 1;
    y_sel = 0;
    gr5 = 32'h0000_0010;
    gr6 = 32'h1234_fffe;
    xy(2'h1, 2'h1);
    chk("y addr", 32'h0000_7fff, y_addr_r);
    chk("y half", 32'h1234_0000, wb_b_data_r);
    // single moves: every mode, word and long, pointer r2 plus mode
    gr2 = 32'h0000_1000;
    gr3 = 32'h0000_2000;
    gr4 = 32'h0000_3000;
    gr5 = 32'h0000_4000;
    gr8 = 32'h0000_0100;
    for (i = 0; i < 8; i = i + 1) begin
      single_sel = i[1:0];
      single_mode = i[1:0];
      single_long = i[2];
      go(2'h2);
      s = i[2] ? 4 : 2;
      b = (i % 4 + 1) * 32'h0000_1000 - (i % 4 == 3 ? s : 0);
      chk("s addr", b, main_addr_r);
      chk("s long", i[2], main_long_r);
      chk("s wb en", i % 4 != 0, wb_a_en_r);
      e = i % 4 == 1 ? b + s : i % 4 == 2 ? b + 32'h0000_0100 : b;
      if (i % 4 != 0) chk("s wb", e, wb_a_data_r);
      if (i % 4 != 0) chk("s num", 2 + i % 4, wb_a_num_r);
    end
    go(2'h3);
    chk("refused", 32'h0000_0000, {x_req_r, main_req_r});
    chk("accesses", 32'h0000_0014, hits);
    wrap_up;
  end
endmodule

// ==== test/xy_memory_model.sv ====
// far-side memory model: tallies x, y and main bus accesses
`timescale 1ns/1ps
module xy_memory_model (
  // clock and strobes
  input wire core_clk,
  input wire x_req_r,
  input wire y_req_r,
  input wire main_req_r,
  // tally
  output reg [7:0] hits
);
  initial hits = 8'h00;
  // x and y may coincide: each has its own bus
  always @(posedge core_clk) begin
    hits <= hits + x_req_r + y_req_r + main_req_r;
  end
endmodule
